// [ptpc_pkg.sv]
// Constants for the timestamp address and port configuration block.
// Assumes a classic Wishbone master on a 10 MHz clock with a synchronous active-high reset.
// Operation
// - Low 32 bits of the user address are a read/write register, reset zero.
// - High 16 bits of the user address come from the companion register bits 15:0.
// - Each port enables the user address with its own configuration bit.
// - Bit 31 set makes port 2 master: capture Sync transmit, Delay_Req receive.
// - Bit 31 clear makes port 2 slave: capture Delay_Req transmit, Sync receive.
// - Bit 30, reset one, enables address 01:00:5E:00:01:81 on port 2.
// - Bit 29, reset zero, enables address 01:00:5E:00:01:82 on port 2.
// - Bit 28, reset zero, enables address 01:00:5E:00:01:83 on port 2.
// - Bit 27, reset zero, enables address 01:00:5E:00:01:84 on port 2.
// - Bit 26, reset zero, enables the user address on port 2.
// - Bit 25, reset one, blocks port 2 receive capture while its interrupt pends.
// - Bit 24, reset one, blocks port 2 transmit capture while its interrupt pends.
// - Bit 23, reset zero, selects master or slave for port 1 likewise.
package ptpc_pkg;
  localparam logic [11:0] ADDR_HIGH_OFS = 12'h18C;
  localparam logic [11:0] ADDR_LOW_OFS = 12'h190;
  localparam logic [11:0] CONFIG_OFS = 12'h194;
  localparam logic [11:0] INT_STATUS_OFS = 12'h198;
  localparam logic [11:0] INT_MASK_OFS = 12'h19C;
  localparam logic [31:0] ADDR_LOW_RST = 32'h0000_0000;
  localparam logic [15:0] ADDR_HIGH_RST = 16'h0000;
  localparam logic [31:0] CONFIG_RST = 32'h4343_0000;
  localparam logic [31:0] CONFIG_WMASK = 32'hFFFF_0000;
  localparam logic [3:0] INT_RST = 4'h0;
  localparam int PORT2_BASE = 31;
  localparam int PORT1_BASE = 23;
  localparam int FLD_MASTER = 7;
  localparam int FLD_PRI = 6;
  localparam int FLD_ALT1 = 5;
  localparam int FLD_ALT2 = 4;
  localparam int FLD_ALT3 = 3;
  localparam int FLD_USER = 2;
  localparam int FLD_LOCK_RX = 1;
  localparam int FLD_LOCK_TX = 0;
  localparam logic [47:0] PRI_ADDR = 48'h0100_5E00_0181;
  localparam logic [47:0] ALT1_ADDR = 48'h0100_5E00_0182;
  localparam logic [47:0] ALT2_ADDR = 48'h0100_5E00_0183;
  localparam logic [47:0] ALT3_ADDR = 48'h0100_5E00_0184;
endpackage

// [ptpc_port.sv]
// Per-port PTP frame classifier and capture gate.
// Assumes frame reports come from logic on the same clock, one cycle each.
`timescale 1ns/100ps
module ptpc_port (
  input wire logic clk_i,
  input wire logic rst_i,
  ptpc_port_if.port pif
);
  logic match;
  logic want;
  logic hit;
  logic cap_rx_d;
  logic cap_tx_d;
  logic cap_rx_q;
  logic cap_tx_q;

  always_comb begin
    // Address match against enabled addresses only
    match = (pif.cfg[ptpc_pkg::FLD_PRI] && pif.frm_da == ptpc_pkg::PRI_ADDR) ||
            (pif.cfg[ptpc_pkg::FLD_ALT1] && pif.frm_da == ptpc_pkg::ALT1_ADDR) ||
            (pif.cfg[ptpc_pkg::FLD_ALT2] && pif.frm_da == ptpc_pkg::ALT2_ADDR) ||
            (pif.cfg[ptpc_pkg::FLD_ALT3] && pif.frm_da == ptpc_pkg::ALT3_ADDR) ||
            (pif.cfg[ptpc_pkg::FLD_USER] && pif.frm_da == pif.user_addr);
    // Master: Sync on transmit, Delay_Req on receive; slave the other way round
    want = pif.cfg[ptpc_pkg::FLD_MASTER] ? (pif.frm_tx == pif.frm_sync)
                                         : (pif.frm_tx != pif.frm_sync);
    hit = pif.frm_valid && match && want;
    cap_rx_d = hit && !pif.frm_tx && !(pif.cfg[ptpc_pkg::FLD_LOCK_RX] && pif.pend_rx);
    cap_tx_d = hit && pif.frm_tx && !(pif.cfg[ptpc_pkg::FLD_LOCK_TX] && pif.pend_tx);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_rx_q <= 1'b0;
      cap_tx_q <= 1'b0;
    end else begin
      cap_rx_q <= cap_rx_d;
      cap_tx_q <= cap_tx_d;
    end
  end

  assign pif.cap_rx = cap_rx_q;
  assign pif.cap_tx = cap_tx_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_lock_rx_holds: assert property (
    pif.cfg[ptpc_pkg::FLD_LOCK_RX] && pif.pend_rx |=> !cap_rx_q)
    else $error("receive capture passed a pending lock");
  a_lock_tx_holds: assert property (
    pif.cfg[ptpc_pkg::FLD_LOCK_TX] && pif.pend_tx |=> !cap_tx_q)
    else $error("transmit capture passed a pending lock");
  a_master_sync_tx: assert property (
    pif.frm_valid && pif.frm_tx && pif.frm_sync && pif.cfg[ptpc_pkg::FLD_MASTER] &&
    pif.cfg[ptpc_pkg::FLD_PRI] && pif.frm_da == ptpc_pkg::PRI_ADDR && !pif.pend_tx
    |=> cap_tx_q)
    else $error("master did not capture Sync transmit");
  a_slave_sync_rx: assert property (
    pif.frm_valid && !pif.frm_tx && pif.frm_sync && !pif.cfg[ptpc_pkg::FLD_MASTER] &&
    pif.cfg[ptpc_pkg::FLD_PRI] && pif.frm_da == ptpc_pkg::PRI_ADDR && !pif.pend_rx
    |=> cap_rx_q)
    else $error("slave did not capture Sync receive");
  a_no_match_quiet: assert property (
    !(pif.frm_valid && pif.cfg[ptpc_pkg::FLD_USER] && pif.frm_da == pif.user_addr) &&
    !(pif.frm_valid && pif.cfg[ptpc_pkg::FLD_PRI] && pif.frm_da == ptpc_pkg::PRI_ADDR) &&
    !(pif.frm_valid && pif.cfg[ptpc_pkg::FLD_ALT1] && pif.frm_da == ptpc_pkg::ALT1_ADDR) &&
    !(pif.frm_valid && pif.cfg[ptpc_pkg::FLD_ALT2] && pif.frm_da == ptpc_pkg::ALT2_ADDR) &&
    !(pif.frm_valid && pif.cfg[ptpc_pkg::FLD_ALT3] && pif.frm_da == ptpc_pkg::ALT3_ADDR)
    |=> !cap_rx_q && !cap_tx_q)
    else $error("capture without an enabled address match");
  c_user_capture: cover property (
    pif.frm_valid && pif.frm_da == pif.user_addr ##1 (cap_rx_q || cap_tx_q));
  c_locked_drop: cover property (pif.frm_valid && pif.pend_tx && pif.frm_tx ##1 !cap_tx_q);
endmodule

// [ptpc_port_if.sv]
// Interface between the register core and one per-port frame classifier.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface ptpc_port_if;
  logic [7:0] cfg;
  logic [47:0] user_addr;
  logic pend_rx;
  logic pend_tx;
  logic frm_valid;
  logic frm_tx;
  logic frm_sync;
  logic [47:0] frm_da;
  logic cap_rx;
  logic cap_tx;
  modport ctl (output cfg, user_addr, pend_rx, pend_tx, frm_valid, frm_tx, frm_sync, frm_da,
               input cap_rx, cap_tx);
  modport port (input cfg, user_addr, pend_rx, pend_tx, frm_valid, frm_tx, frm_sync, frm_da,
                output cap_rx, cap_tx);
endinterface

// [ptpc_top.sv]
// Register core: user address, port configuration, capture interrupts, Wishbone slave.
// Assumes a classic Wishbone master on clk_i and same-clock frame reports per port.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/100ps
module ptpc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic [1:0] frm_valid_i,
  input wire logic [1:0] frm_tx_i,
  input wire logic [1:0] frm_sync_i,
  input wire logic [1:0][47:0] frm_da_i,
  output logic [1:0] cap_rx_o,
  output logic [1:0] cap_tx_o
);
  logic [31:0] addr_low_q;
  logic [31:0] addr_low_d;
  logic [15:0] addr_high_q;
  logic [15:0] addr_high_d;
  logic [31:0] config_q;
  logic [31:0] config_d;
  logic [3:0] sts_q;
  logic [3:0] sts_d;
  logic [3:0] msk_q;
  logic [3:0] msk_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic ack_q;
  logic ack_d;
  logic irq_q;
  logic irq_d;
  logic req;
  logic wr;
  logic [3:0] set;
  logic [3:0] clr;
  logic [47:0] user_addr;
  logic [1:0] cap_rx;
  logic [1:0] cap_tx;

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Register hit for a word offset
  function automatic logic hit_ofs(input logic [11:0] adr, input logic [11:0] ofs);
    return adr[11:2] == ofs[11:2];
  endfunction

  assign user_addr = {addr_high_q, addr_low_q};

  generate
    for (genvar p = 0; p < 2; p++) begin : g_port
      localparam int BASE = (p == 1) ? ptpc_pkg::PORT2_BASE : ptpc_pkg::PORT1_BASE;
      ptpc_port_if pif();
      assign pif.cfg = config_q[BASE -: 8];
      assign pif.user_addr = user_addr;
      assign pif.pend_rx = sts_q[2*p] | pif.cap_rx;
      assign pif.pend_tx = sts_q[2*p+1] | pif.cap_tx;
      assign pif.frm_valid = frm_valid_i[p];
      assign pif.frm_tx = frm_tx_i[p];
      assign pif.frm_sync = frm_sync_i[p];
      assign pif.frm_da = frm_da_i[p];
      assign cap_rx[p] = pif.cap_rx;
      assign cap_tx[p] = pif.cap_tx;
      ptpc_port u_port (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pif(pif.port)
      );
    end
  endgenerate

  always_comb begin
    req = wb_cyc_i && wb_stb_i && !ack_q;
    wr = req && wb_we_i;
    addr_low_d = addr_low_q;
    addr_high_d = addr_high_q;
    config_d = config_q;
    msk_d = msk_q;
    clr = 4'h0;
    if (wr && hit_ofs(wb_adr_i, ptpc_pkg::ADDR_LOW_OFS)) begin
      addr_low_d = merge(addr_low_q, wb_dat_i, wb_sel_i);
    end
    if (wr && hit_ofs(wb_adr_i, ptpc_pkg::ADDR_HIGH_OFS)) begin
      addr_high_d = 16'(merge({16'h0000, addr_high_q}, wb_dat_i, wb_sel_i));
    end
    if (wr && hit_ofs(wb_adr_i, ptpc_pkg::CONFIG_OFS)) begin
      config_d = merge(config_q, wb_dat_i, wb_sel_i) & ptpc_pkg::CONFIG_WMASK;
    end
    if (wr && hit_ofs(wb_adr_i, ptpc_pkg::INT_MASK_OFS) && wb_sel_i[0]) begin
      msk_d = wb_dat_i[3:0];
    end
    if (wr && hit_ofs(wb_adr_i, ptpc_pkg::INT_STATUS_OFS) && wb_sel_i[0]) begin
      clr = wb_dat_i[3:0];
    end
    // Status: port 1 rx/tx in bits 1:0, port 2 rx/tx in bits 3:2; set beats clear
    set = {cap_tx[1], cap_rx[1], cap_tx[0], cap_rx[0]};
    sts_d = (sts_q & ~clr) | set;
    irq_d = |(sts_q & msk_q);
    ack_d = req;
    dat_d = 32'h0000_0000;
    if (req && !wb_we_i) begin
      if (hit_ofs(wb_adr_i, ptpc_pkg::ADDR_LOW_OFS)) begin
        dat_d = addr_low_q;
      end else if (hit_ofs(wb_adr_i, ptpc_pkg::ADDR_HIGH_OFS)) begin
        dat_d = {16'h0000, addr_high_q};
      end else if (hit_ofs(wb_adr_i, ptpc_pkg::CONFIG_OFS)) begin
        dat_d = config_q;
      end else if (hit_ofs(wb_adr_i, ptpc_pkg::INT_STATUS_OFS)) begin
        dat_d = {28'h0000000, sts_q};
      end else if (hit_ofs(wb_adr_i, ptpc_pkg::INT_MASK_OFS)) begin
        dat_d = {28'h0000000, msk_q};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_low_q <= ptpc_pkg::ADDR_LOW_RST;
      addr_high_q <= ptpc_pkg::ADDR_HIGH_RST;
      config_q <= ptpc_pkg::CONFIG_RST;
      sts_q <= ptpc_pkg::INT_RST;
      msk_q <= ptpc_pkg::INT_RST;
      dat_q <= 32'h0000_0000;
      ack_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      addr_low_q <= addr_low_d;
      addr_high_q <= addr_high_d;
      config_q <= config_d;
      sts_q <= sts_d;
      msk_q <= msk_d;
      dat_q <= dat_d;
      ack_q <= ack_d;
      irq_q <= irq_d;
    end
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign irq_o = irq_q;
  assign cap_rx_o = cap_rx;
  assign cap_tx_o = cap_tx;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !ack_q |=> ack_q)
    else $error("no ack one cycle after a request");
  a_ack_single_cycle: assert property (ack_q |=> !ack_q)
    else $error("ack held longer than one cycle");
  a_addr_low_write: assert property (
    wr && hit_ofs(wb_adr_i, ptpc_pkg::ADDR_LOW_OFS) && wb_sel_i == 4'hF
    |=> addr_low_q == $past(wb_dat_i))
    else $error("low address word not written");
  a_user_addr_join: assert property (
    wr && hit_ofs(wb_adr_i, ptpc_pkg::ADDR_HIGH_OFS) && wb_sel_i == 4'hF
    |=> user_addr[47:32] == $past(wb_dat_i[15:0]) && user_addr[31:0] == addr_low_q)
    else $error("user address high half not taken");
  a_config_reset: assert property (
    $fell(rst_i) |-> config_q == ptpc_pkg::CONFIG_RST && addr_low_q == ptpc_pkg::ADDR_LOW_RST)
    else $error("configuration not at reset value");
  a_port1_mode_write: assert property (
    wr && hit_ofs(wb_adr_i, ptpc_pkg::CONFIG_OFS) && wb_sel_i[2]
    |=> config_q[ptpc_pkg::PORT1_BASE] == $past(wb_dat_i[ptpc_pkg::PORT1_BASE]))
    else $error("port 1 master select not written");
  a_set_beats_clear: assert property (
    set[3] && clr[3] |=> sts_q[3])
    else $error("capture event lost under a clear");
  a_irq_level: assert property (
    ##1 irq_o == $past(|(sts_q & msk_q)))
    else $error("interrupt not tracking masked status");
  c_read_config: cover property (req && !wb_we_i && hit_ofs(wb_adr_i, ptpc_pkg::CONFIG_OFS));
  c_irq_raised: cover property ($rose(irq_o));
  c_p2_tx_capture: cover property (cap_tx[1] ##1 sts_q[3]);
endmodule

// [tb_top.sv]
// Self-checking testbench for the timestamp address and port configuration block.
// Assumes the design's classic Wishbone slave and one-cycle frame report inputs.
`timescale 1ns/100ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic irq_o;
  logic [1:0] frm_valid_i = 2'h0;
  logic [1:0] frm_tx_i = 2'h0;
  logic [1:0] frm_sync_i = 2'h0;
  logic [1:0][47:0] frm_da_i = '0;
  logic [1:0] cap_rx_o;
  logic [1:0] cap_tx_o;
  int fails = 0;
  int n_compared = 0;
  logic [31:0] rd;
  logic [47:0] addr [5];
  logic tx, sync, cap;
  ptpc_top i_ptpc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .frm_valid_i(frm_valid_i),
    .frm_tx_i(frm_tx_i), .frm_sync_i(frm_sync_i), .frm_da_i(frm_da_i), .cap_rx_o(cap_rx_o),
    .cap_tx_o(cap_tx_o));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  // One classic Wishbone cycle, held until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [11:0] adr, input logic [3:0] sel,
                         input logic [31:0] dat, output logic [31:0] data);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    data = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
    wb_xfer(1'b1, adr, 4'hF, dat, rd);
  endtask
  task automatic rdchk(input logic [11:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 4'hF, 32'h0, rd);
    chk(rd, exp, "register read");
  endtask
  // One frame report on port p, then the capture pulses one cycle later
  task automatic frame(input int p, input logic ftx, input logic fsync, input logic [47:0] da,
                       input logic [1:0] erx, input logic [1:0] etx);
    @(posedge clk_i);
    frm_valid_i[p] <= 1'b1;
    frm_tx_i[p] <= ftx;
    frm_sync_i[p] <= fsync;
    frm_da_i[p] <= da;
    @(posedge clk_i);
    frm_valid_i[p] <= 1'b0;
    frm_da_i[p] <= ~da;
    @(posedge clk_i);
    chk({30'h0, cap_rx_o}, {30'h0, erx}, "rx capture");
    chk({30'h0, cap_tx_o}, {30'h0, etx}, "tx capture");
  endtask
  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(ptpc_pkg::ADDR_LOW_OFS, 32'h0000_0000);
    rdchk(ptpc_pkg::ADDR_HIGH_OFS, 32'h0000_0000);
    rdchk(ptpc_pkg::CONFIG_OFS, 32'h4343_0000);
    rdchk(ptpc_pkg::INT_STATUS_OFS, 32'h0);
    rdchk(ptpc_pkg::INT_MASK_OFS, 32'h0);
    rdchk(12'h1A0, 32'h0);
    $display("Test reset values done");
    wr(ptpc_pkg::ADDR_LOW_OFS, 32'hA5C3_0F12);
    wb_xfer(1'b1, ptpc_pkg::ADDR_LOW_OFS, 4'h2, 32'hFFFF_FFFF, rd);
    rdchk(ptpc_pkg::ADDR_LOW_OFS, 32'hA5C3_FF12);
    wr(ptpc_pkg::ADDR_HIGH_OFS, 32'hFFFF_0240);
    rdchk(ptpc_pkg::ADDR_HIGH_OFS, 32'h0000_0240);
    wr(ptpc_pkg::CONFIG_OFS, 32'hFFFF_FFFF);
    rdchk(ptpc_pkg::CONFIG_OFS, 32'hFFFF_0000);
    wr(12'h1A0, 32'hFFFF_FFFF);
    rdchk(12'h1A0, 32'h0);
    $display("Test register access done");
    addr = '{48'h0100_5E00_0181, 48'h0100_5E00_0182, 48'h0100_5E00_0183,
             48'h0100_5E00_0184, 48'h0240_A5C3_FF12};
    for (int i = 0; i < 5; i++) begin
      wr(ptpc_pkg::CONFIG_OFS, {8'h80 | (8'h40 >> i), 24'h0});
      for (int j = 0; j < 5; j++) begin
        cap = (i == j);
        frame(1, 1'b1, 1'b1, addr[j], 2'b00, {cap, 1'b0});
      end
    end
    wr(ptpc_pkg::CONFIG_OFS, 32'h8084_0000);
    frame(0, 1'b1, 1'b1, addr[4], 2'b00, 2'b01);
    frame(1, 1'b1, 1'b1, addr[4], 2'b00, 2'b00);
    $display("Test address enables done");
    for (int ms = 0; ms < 2; ms++) begin
      wr(ptpc_pkg::CONFIG_OFS, {ms[0], 7'h40, ms[0], 7'h40, 16'h0});
      for (int k = 0; k < 8; k++) begin
        tx = k[1];
        sync = k[0];
        cap = (ms == 1) ? (tx == sync) : (tx != sync);
        frame(k / 4, tx, sync, addr[0], (cap && !tx) ? 2'(1 << (k / 4)) : 2'b00,
              (cap && tx) ? 2'(1 << (k / 4)) : 2'b00);
      end
    end
    $display("Test master and slave done");
    wr(ptpc_pkg::INT_STATUS_OFS, 32'hF);
    wr(ptpc_pkg::CONFIG_OFS, 32'hC300_0000);
    for (int l = 0; l < 2; l++) begin
      frame(1, l[0], l[0], addr[0], l ? 2'b00 : 2'b10, l ? 2'b10 : 2'b00);
      rdchk(ptpc_pkg::INT_STATUS_OFS, 32'(1 << (2 + l)));
      chk({31'h0, irq_o}, 32'h0, "masked irq");
      frame(1, l[0], l[0], addr[0], 2'b00, 2'b00);
      wr(ptpc_pkg::INT_MASK_OFS, 32'(1 << (2 + l)));
      rdchk(ptpc_pkg::INT_MASK_OFS, 32'(1 << (2 + l)));
      chk({31'h0, irq_o}, 32'h1, "unmasked irq");
      wr(ptpc_pkg::INT_STATUS_OFS, 32'(1 << (2 + l)));
      rdchk(ptpc_pkg::INT_STATUS_OFS, 32'h0);
      chk({31'h0, irq_o}, 32'h0, "cleared irq");
      frame(1, l[0], l[0], addr[0], l ? 2'b00 : 2'b10, l ? 2'b10 : 2'b00);
      wr(ptpc_pkg::INT_MASK_OFS, 32'h0);
      wr(ptpc_pkg::INT_STATUS_OFS, 32'hF);
    end
    wr(ptpc_pkg::CONFIG_OFS, 32'hC000_0000);
    frame(1, 1'b1, 1'b1, addr[0], 2'b00, 2'b10);
    frame(1, 1'b1, 1'b1, addr[0], 2'b00, 2'b10);
    // Capture and a clearing write land on the same edge: the set must win
    wr(ptpc_pkg::INT_STATUS_OFS, 32'hF);
    fork
      frame(1, 1'b1, 1'b1, addr[0], 2'b00, 2'b10);
      begin
        @(posedge clk_i);
        wr(ptpc_pkg::INT_STATUS_OFS, 32'h8);
      end
    join
    rdchk(ptpc_pkg::INT_STATUS_OFS, 32'h8);
    $display("Test locks and interrupt done");
    print_verdict();
  end
endmodule
